// ===== host_port_pkg.sv
// Shared constants and carrier types for the host port control two and scratchpad block.
`default_nettype none
package host_port_pkg;

  localparam int BYTE_W = 8;

  localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
  localparam logic [4:0] ADDR_SCRATCH  = 5'h02;
  localparam logic [4:0] ADDR_STATUS   = 5'h03;
  localparam logic [4:0] ADDR_CFG_DATA = 5'h04;

  localparam int BIT_IRQ_CFG = 0;
  localparam int BIT_IRQ_ERR = 1;
  localparam int BIT_IRQ_USR = 2;
  localparam int BIT_CHAIN   = 3;
  localparam int BIT_HOLD    = 4;
  localparam int BIT_USER    = 5;

  localparam logic [7:0] CTRL_TWO_MASK  = 8'h3F;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00;
  localparam logic [1:0] ERR_NONE       = 2'h0;

  localparam int ST_DATA_READY = 1;
  localparam int ST_IRQ_PEND   = 2;
  localparam int ST_ERR_LO     = 3;
  localparam int ST_INIT       = 6;
  localparam int ST_DONE       = 7;

  localparam int SER_BITS = 8;

  typedef struct packed
  {
    logic       start;
    logic       write;
    logic [4:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed
  {
    logic [7:0] rdata;
    logic       ack;
  } host_resp_t;

  typedef struct packed
  {
    logic       cfg_mode;
    logic [1:0] cfg_error;
    logic       done;
    logic       init;
    logic       stream_user_mode;
    logic       user_irq_n;
  } core_status_t;

  localparam core_status_t CORE_STATUS_RESET = 7'h01;

endpackage
`default_nettype wire

// ===== bit_sync.sv
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/1ps
`default_nettype none
module bit_sync
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage    <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule
`default_nettype wire

// ===== host_port_regs.sv
// Host port scratchpad, second control register, status view and chain serialiser.
// Notes on behaviour
// - Eight-bit scratchpad is read back exactly as written and steers nothing.
// - Second control register reads back the control bits last written.
// - Bit 0 lets data request raise interrupt; daisy-chain only; resets to 0.
// - Bit 1 lets a bit stream error raise the interrupt; resets to 0.
// - Error interrupt enable matters only while configuration mode is active.
// - Bit 2 lets low user interrupt line raise host interrupt; resets to 0.
// - Bit 3 enables chain serial output of written configuration bytes.
// - Bit 4 holds the write acknowledge until the byte has been serialised; only with bit 3 set.
// - Bytes are serialised only while the chain output enable is set.
// - With bit 4 clear every configuration byte write is acknowledged at once.
// - Bit 5 enables the port for user mode after configuration.
// - The bit stream can also request user mode instead of bit 5.
// - Status register is read only; host writes leave it unchanged.
// - All port registers are eight bits wide, bit 7 most significant.
// - Data ready status is set while configuring and a byte can be taken.
`timescale 1ns/1ps
`default_nettype none
module host_port_regs
#(
  parameter int SER_BITS = host_port_pkg::SER_BITS
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       host_port_clock,
  input  wire host_port_pkg::host_req_t    host_req,
  output var  host_port_pkg::host_resp_t   host_resp,
  output var  logic                       irq_n,
  output var  logic                       user_mode_active,
  input  wire host_port_pkg::core_status_t core_status,
  output var  logic                       chain_data,
  output var  logic                       chain_valid
);

  if (SER_BITS < 1 || SER_BITS > host_port_pkg::BYTE_W)
  begin : g_bad_ser
    $error("SER_BITS must lie between 1 and the byte width.");
  end

  typedef enum logic [2:0]
  {
    S_IDLE   = 3'b001,
    S_SHIFT  = 3'b010,
    S_RETURN = 3'b100
  } ser_state_t;

  logic                       link_rst_n;
  host_port_pkg::core_status_t status_s;
  logic                       ack_s;
  logic [1:0]                 core_s;
  logic [7:0]                 scratchpad;
  logic [7:0]                 ctrl_two;
  logic                       irq_pending;
  logic                       req_tog;
  logic [7:0]                 cfg_byte;
  logic                       hold_wait;
  logic                       done_q;
  ser_state_t                 state;
  logic [7:0]                 shift;
  logic [3:0]                 bit_cnt;
  logic                       req_seen;
  logic                       ack_tog;

  // Reset for the link domain, released on the link clock.
  bit_sync #(.WIDTH(1), .INIT(1'b0)) u_link_rst
  (
    .clk      (host_port_clock),
    .rst_n    (1'b1),
    .async_in (rst_n),
    .sync_out (link_rst_n)
  );

  bit_sync #(.WIDTH($bits(host_port_pkg::core_status_t)),
             .INIT(host_port_pkg::CORE_STATUS_RESET)) u_status_sync
  (
    .clk      (host_port_clock),
    .rst_n    (link_rst_n),
    .async_in (core_status),
    .sync_out (status_s)
  );

  bit_sync #(.WIDTH(1), .INIT(1'b0)) u_ack_sync
  (
    .clk      (host_port_clock),
    .rst_n    (link_rst_n),
    .async_in (ack_tog),
    .sync_out (ack_s)
  );

  bit_sync #(.WIDTH(2), .INIT(2'h0)) u_core_sync
  (
    .clk      (clk_sys),
    .rst_n    (rst_n),
    .async_in ({ctrl_two[host_port_pkg::BIT_CHAIN], req_tog}),
    .sync_out (core_s)
  );

  // Link side decode.
  wire accept    = host_req.start & ~hold_wait;
  wire acc_write = accept & host_req.write;
  wire acc_read  = accept & ~host_req.write;
  wire hit_ctrl  = host_req.addr == host_port_pkg::ADDR_CTRL_TWO;
  wire hit_scr   = host_req.addr == host_port_pkg::ADDR_SCRATCH;
  wire hit_stat  = host_req.addr == host_port_pkg::ADDR_STATUS;
  wire hit_cfg   = host_req.addr == host_port_pkg::ADDR_CFG_DATA;
  wire busy      = req_tog != ack_s;
  wire data_rdy  = status_s.cfg_mode & ~busy;
  wire cfg_write = acc_write & hit_cfg;
  wire send      = cfg_write & ctrl_two[host_port_pkg::BIT_CHAIN] & ~busy;
  wire hold_now  = send & ctrl_two[host_port_pkg::BIT_HOLD];
  wire ack_now   = (accept & ~hold_now) | (hold_wait & ~busy);

  // Interrupt sources, each gated by its enable.
  wire cfg_src = ctrl_two[host_port_pkg::BIT_IRQ_CFG] & ctrl_two[host_port_pkg::BIT_CHAIN]
               & data_rdy;
  wire err_src = ctrl_two[host_port_pkg::BIT_IRQ_ERR] & status_s.cfg_mode
               & (status_s.cfg_error != host_port_pkg::ERR_NONE);
  wire usr_src = ctrl_two[host_port_pkg::BIT_IRQ_USR] & ~status_s.user_irq_n;
  wire any_irq = cfg_src | err_src | usr_src;

  wire [7:0] status_byte;
  assign status_byte[0]                         = 1'b0;
  assign status_byte[host_port_pkg::ST_DATA_READY] = data_rdy;
  assign status_byte[host_port_pkg::ST_IRQ_PEND]   = irq_pending;
  assign status_byte[host_port_pkg::ST_ERR_LO+1:host_port_pkg::ST_ERR_LO] = status_s.cfg_error;
  assign status_byte[5]                         = 1'b0;
  assign status_byte[host_port_pkg::ST_INIT]       = status_s.init;
  assign status_byte[host_port_pkg::ST_DONE]       = status_s.done;

  wire [7:0] read_mux = hit_scr  ? scratchpad :
                        hit_ctrl ? ctrl_two :
                        hit_stat ? status_byte :
                        host_port_pkg::READ_IDLE;

  wire done_rise = status_s.done & ~done_q;
  wire user_req  = ctrl_two[host_port_pkg::BIT_USER] | status_s.stream_user_mode;

  always_ff @(posedge host_port_clock)
  begin
    if (!link_rst_n)
    begin
      scratchpad       <= host_port_pkg::SCRATCH_RESET;
      ctrl_two         <= host_port_pkg::CTRL_TWO_RESET;
      irq_pending      <= 1'b0;
      req_tog          <= 1'b0;
      cfg_byte         <= 8'h00;
      hold_wait        <= 1'b0;
      done_q           <= 1'b0;
      host_resp        <= '0;
      irq_n            <= 1'b1;
      user_mode_active <= 1'b0;
    end
    else
    begin
      if (acc_write & hit_scr)
        scratchpad <= host_req.wdata;
      if (acc_write & hit_ctrl)
        ctrl_two <= host_req.wdata & host_port_pkg::CTRL_TWO_MASK;
      irq_pending <= any_irq | (irq_pending & ~(acc_read & hit_stat));
      if (send)
      begin
        req_tog  <= ~req_tog;
        cfg_byte <= host_req.wdata;
      end
      hold_wait       <= hold_now | (hold_wait & busy);
      done_q          <= status_s.done;
      host_resp.ack   <= ack_now;
      host_resp.rdata <= acc_read ? read_mux : host_port_pkg::READ_IDLE;
      irq_n           <= ~any_irq;
      if (done_rise)
        user_mode_active <= user_req;
      else if (!status_s.done)
        user_mode_active <= 1'b0;
    end
  end

  // Serialiser on the system clock.
  wire new_req = core_s[0] != req_seen;
  wire last    = bit_cnt == 4'(SER_BITS - 1);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state       <= S_IDLE;
      shift       <= 8'h00;
      bit_cnt     <= 4'h0;
      req_seen    <= 1'b0;
      ack_tog     <= 1'b0;
      chain_data  <= 1'b0;
      chain_valid <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          chain_valid <= 1'b0;
          if (new_req)
          begin
            req_seen <= core_s[0];
            shift    <= cfg_byte;
            bit_cnt  <= 4'h0;
            state    <= core_s[1] ? S_SHIFT : S_RETURN;
          end
        end
        S_SHIFT:
        begin
          chain_data  <= shift[7];
          chain_valid <= 1'b1;
          shift       <= {shift[6:0], 1'b0};
          bit_cnt     <= bit_cnt + 4'h1;
          if (last)
            state <= S_RETURN;
        end
        S_RETURN:
        begin
          chain_valid <= 1'b0;
          ack_tog     <= ~ack_tog;
          state       <= S_IDLE;
        end
        default:
        begin
          state       <= S_IDLE;
          chain_valid <= 1'b0;
        end
      endcase
    end
  end

  chk_scratch_readback: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    (acc_write && hit_scr) ##3 (acc_read && hit_scr) |=>
      host_resp.rdata == $past(host_req.wdata, 4))
    else $error("Scratchpad did not read back the written byte.");

  chk_ctrl_two_read: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    acc_read && hit_ctrl |=>
      host_resp.rdata == {2'b00, $past(ctrl_two[5:0])})
    else $error("Control two read value differs from stored bits.");

  chk_reserved_zero: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    (acc_write && hit_ctrl) ##3 (acc_read && hit_ctrl) |=> host_resp.rdata[7:6] == 2'b00)
    else $error("Reserved control two bits did not read zero.");

  chk_cfg_irq: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    cfg_src |=> !irq_n)
    else $error("Configuration data request did not raise interrupt.");

  chk_err_irq: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    ctrl_two[1] && status_s.cfg_mode && status_s.cfg_error != 2'b00 |=> !irq_n)
    else $error("Bit stream error did not raise interrupt.");

  chk_err_outside: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    !status_s.cfg_mode && !ctrl_two[2] |=> irq_n)
    else $error("Interrupt raised outside configuration without user source.");

  chk_user_irq: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    ctrl_two[2] && !status_s.user_irq_n |=> !irq_n)
    else $error("User interrupt did not reach the interrupt output.");

  chk_no_send: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    cfg_write && !ctrl_two[3] |=> $stable(req_tog))
    else $error("Byte sent for serialisation with chain output off.");

  chk_hold_ack: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    hold_now |=> !host_resp.ack ##1 !host_resp.ack ##[1:60] host_resp.ack)
    else $error("Held write acknowledged early or never.");

  chk_imm_ack: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    cfg_write && !ctrl_two[4] |=> host_resp.ack)
    else $error("Configuration write not acknowledged at once.");

  chk_status_ro: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    acc_write && hit_stat |=> irq_pending == ($past(irq_pending) || $past(any_irq)))
    else $error("Status write changed status contents.");

  chk_user_mode: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    done_rise && user_req |=> user_mode_active)
    else $error("User mode not enabled at done.");

  chk_data_ready: assert property (
    @(posedge host_port_clock) disable iff (!link_rst_n)
    send |=> !status_byte[host_port_pkg::ST_DATA_READY])
    else $error("Data ready shown while a byte is in flight.");

  chk_ser_length: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(chain_valid) |-> chain_valid [*8] ##1 !chain_valid)
    else $error("Serialised byte length is wrong.");

  cov_hold_write: cover property (@(posedge host_port_clock) disable iff (!link_rst_n)
    hold_now ##[2:60] host_resp.ack);
  cov_user_irq: cover property (@(posedge host_port_clock) disable iff (!link_rst_n)
    usr_src ##1 !irq_n);
  cov_user_mode: cover property (@(posedge host_port_clock) disable iff (!link_rst_n)
    done_rise && user_req);
  cov_serial: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(chain_valid));

endmodule
`default_nettype wire

// ===== host_cpu_model.sv
// Host processor model issuing single byte accesses on the port clock.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
(
  input  wire logic                      clk,
  input  wire host_port_pkg::host_resp_t resp,
  output var  host_port_pkg::host_req_t  req
);
  initial req = '0;

  // One access: start pulses once, the rest holds past the edge that samples ack.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output int lat);
    @(posedge clk);
    #1;
    req = '{start: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req.start = 1'b0;
    lat = 1;
    while (lat < 100 && resp.ack !== 1'b1)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    @(posedge clk);
    #1;
    req = {1'b0, ~req.write, ~req.addr, ~req.wdata};
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the host port register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                        clk_sys         = 1'b0;
  logic                        host_port_clock = 1'b0;
  logic                        rst_n           = 1'b0;
  host_port_pkg::host_req_t    req;
  host_port_pkg::host_resp_t   resp;
  host_port_pkg::core_status_t cs = host_port_pkg::CORE_STATUS_RESET;
  logic                        irq_n;
  logic                        uma;
  logic                        chain_data;
  logic                        chain_valid;
  logic [15:0]                 note;
  logic [15:0]                 resp_q[$];
  logic [7:0]                  chain_q[$];
  logic [7:0]                  sh;
  logic [7:0]                  v;
  int                          num_errors = 0;
  int                          checks     = 0;
  int                          cnt        = 0;
  int                          lat;

  localparam logic [4:0] CTL = host_port_pkg::ADDR_CTRL_TWO;
  localparam logic [4:0] SCR = host_port_pkg::ADDR_SCRATCH;
  localparam logic [4:0] STS = host_port_pkg::ADDR_STATUS;
  localparam logic [4:0] CFG = host_port_pkg::ADDR_CFG_DATA;

  always #12.5 clk_sys = ~clk_sys;
  always #16 host_port_clock = ~host_port_clock;

  host_port_regs i_dut
  (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .host_port_clock  (host_port_clock),
    .host_req         (req),
    .host_resp        (resp),
    .irq_n            (irq_n),
    .user_mode_active (uma),
    .core_status      (cs),
    .chain_data       (chain_data),
    .chain_valid      (chain_valid)
  );

  host_cpu_model i_host
  (
    .clk  (host_port_clock),
    .resp (resp),
    .req  (req)
  );

  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp)
      fail(m);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Notes the expected read data under a mask, then runs the access.
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic [7:0] m);
    resp_q.push_back({m, e});
    i_host.xfer(w, a, d, lat);
    if (lat >= 100)
    begin
      fail("no acknowledge");
      wrap_up();
    end
  endtask

  task automatic link(input int n);
    repeat (n) @(posedge host_port_clock);
    #1;
  endtask

  task automatic irq_case(input logic [7:0] c, input logic md, input logic [1:0] er,
                          input logic u, input logic e);
    cs.cfg_mode   = md;
    cs.cfg_error  = er;
    cs.user_irq_n = u;
    acc(1'b1, CTL, c, 8'h00, 8'hFF);
    link(6);
    check({7'h00, irq_n}, {7'h00, e}, "interrupt level");
    cs.cfg_mode   = 1'b0;
    cs.cfg_error  = 2'h0;
    cs.user_irq_n = 1'b1;
  endtask

  task automatic um_case(input logic b, input logic s, input logic e);
    cs.cfg_mode         = 1'b1;
    cs.stream_user_mode = s;
    acc(1'b1, CTL, {2'h0, b, 5'h00}, 8'h00, 8'hFF);
    link(4);
    acc(1'b0, STS, 8'h00, 8'h02, 8'h02);
    cs.done = 1'b1;
    link(6);
    check({7'h00, uma}, {7'h00, e}, "user mode after done");
    cs.done = 1'b0;
    link(6);
    check({7'h00, uma}, 8'h00, "user mode after done low");
  endtask

  // Takes the oldest note at every acknowledge and compares the read data.
  always @(posedge host_port_clock)
  begin
    if (resp.ack === 1'b1)
    begin
      checks++;
      if (resp_q.size() == 0)
        fail("unexpected acknowledge");
      else
      begin
        note = resp_q.pop_front();
        if ((resp.rdata & note[15:8]) !== note[7:0])
          fail("read data");
      end
    end
  end

  // Collects each serialised byte, most significant bit first.
  always @(posedge clk_sys)
  begin
    if (chain_valid === 1'b1)
    begin
      sh = {sh[6:0], chain_data};
      cnt++;
      if (cnt == 8)
      begin
        cnt = 0;
        checks++;
        if (chain_q.size() == 0)
          fail("unexpected chain byte");
        else if (chain_q.pop_front() !== sh)
          fail("chain byte");
      end
    end
  end

  initial
  begin
    void'($urandom(32'h03E0ED01));
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    link(4);
    acc(1'b0, CTL, 8'h00, 8'h00, 8'hFF);
    acc(1'b0, SCR, 8'h00, 8'h00, 8'hFF);
    $display("reset test done");
    repeat (4)
    begin
      v = 8'($urandom);
      acc(1'b1, SCR, v, 8'h00, 8'hFF);
      acc(1'b0, SCR, 8'h00, v, 8'hFF);
      acc(1'b1, CTL, ~v, 8'h00, 8'hFF);
      acc(1'b0, CTL, 8'h00, ~v & 8'h3F, 8'hFF);
    end
    $display("readback test done");
    cs.done      = 1'b1;
    cs.init      = 1'b1;
    cs.cfg_error = 2'h2;
    acc(1'b1, STS, 8'hFF, 8'h00, 8'hFF);
    link(6);
    acc(1'b0, STS, 8'h00, 8'hD0, 8'hD8);
    acc(1'b1, 5'h05, 8'h5A, 8'h00, 8'hFF);
    acc(1'b0, 5'h05, 8'h00, 8'h00, 8'hFF);
    cs.done      = 1'b0;
    cs.init      = 1'b0;
    cs.cfg_error = 2'h0;
    $display("status test done");
    irq_case(8'h04, 1'b0, 2'h0, 1'b0, 1'b0);
    irq_case(8'h00, 1'b0, 2'h0, 1'b0, 1'b1);
    irq_case(8'h02, 1'b1, 2'h1, 1'b1, 1'b0);
    irq_case(8'h02, 1'b0, 2'h1, 1'b1, 1'b1);
    irq_case(8'h09, 1'b1, 2'h0, 1'b1, 1'b0);
    irq_case(8'h01, 1'b1, 2'h0, 1'b1, 1'b1);
    $display("interrupt test done");
    acc(1'b1, CTL, 8'h08, 8'h00, 8'hFF);
    v = 8'($urandom);
    chain_q.push_back(v);
    acc(1'b1, CFG, v, 8'h00, 8'hFF);
    check({7'h00, lat == 1}, 8'h01, "immediate ack");
    for (int i = 0; i < 100 && chain_q.size() != 0; i++)
      @(posedge clk_sys);
    check({7'h00, chain_q.size() == 0}, 8'h01, "chain byte missing");
    if (chain_q.size() != 0)
      wrap_up();
    acc(1'b1, CTL, 8'h18, 8'h00, 8'hFF);
    v = 8'($urandom);
    chain_q.push_back(v);
    acc(1'b1, CFG, v, 8'h00, 8'hFF);
    check({7'h00, chain_q.size() == 0}, 8'h01, "held ack too early");
    acc(1'b1, CTL, 8'h10, 8'h00, 8'hFF);
    acc(1'b1, CFG, 8'($urandom), 8'h00, 8'hFF);
    check({7'h00, lat == 1}, 8'h01, "ack without chain");
    link(12);
    $display("chain test done");
    um_case(1'b1, 1'b0, 1'b1);
    um_case(1'b0, 1'b1, 1'b1);
    um_case(1'b0, 1'b0, 1'b0);
    $display("user mode test done");
    link(4);
    check({7'h00, resp_q.size() == 0}, 8'h01, "missing acknowledge");
    wrap_up();
  end
endmodule
`default_nettype wire
